// ==== common/asc_pkg.sv ====
// Purpose: Constants for the asynchronous 64K x 8 SRAM controller.
// Assumes: 100 MHz system clock, period 10 ns.
// Notes:   Times are in ns; cycle counts are derived and rounded up.
package asc_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W        = 16;
  localparam int DATA_W        = 8;

  // Figures of the 70 ns speed grade; a faster grade needs these values changed.
  localparam int WRITE_PULSE_MIN_NS         = 50;
  localparam int SELECT_TO_WRITE_END_NS     = 60;
  localparam int ADDR_VALID_TO_WRITE_END_NS = 60;
  localparam int DATA_OVERLAP_MIN_NS        = 30;
  localparam int DATA_HOLD_AFTER_NS         = 0;
  localparam int ADDR_SETUP_TO_WRITE_NS     = 0;
  localparam int WRITE_RECOVERY_NS          = 0;
  localparam int READ_CYCLE_MIN_NS          = 70;
  localparam int WRITE_CYCLE_MIN_NS         = 70;
  localparam int DISABLE_TO_FLOAT_NS        = 25;

  // Least times round up to whole cycles, never below one.
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WRITE_PULSE_CYC   = cyc_up(WRITE_PULSE_MIN_NS);
  localparam int SEL_WEND_CYC      = cyc_up(SELECT_TO_WRITE_END_NS);
  localparam int ADDR_WEND_CYC     = cyc_up(ADDR_VALID_TO_WRITE_END_NS);
  localparam int DATA_OVERLAP_CYC  = cyc_up(DATA_OVERLAP_MIN_NS);
  localparam int DATA_HOLD_CYC     = cyc_up(DATA_HOLD_AFTER_NS);
  localparam int ADDR_SETUP_CYC    = cyc_up(ADDR_SETUP_TO_WRITE_NS);
  localparam int RECOVERY_CYC      = cyc_up(WRITE_RECOVERY_NS);
  localparam int READ_CYCLE_CYC    = cyc_up(READ_CYCLE_MIN_NS);
  localparam int WRITE_CYCLE_CYC   = cyc_up(WRITE_CYCLE_MIN_NS);
  localparam int FLOAT_CYC         = cyc_up(DISABLE_TO_FLOAT_NS);

  localparam int CNT_W = 8;

  typedef enum logic [2:0]
  {
    ASC_IDLE  = 3'b000,
    ASC_WSET  = 3'b001,
    ASC_WPUL  = 3'b010,
    ASC_WREC  = 3'b011,
    ASC_RACC  = 3'b100,
    ASC_RFLT  = 3'b101
  } asc_state_type;

endpackage

// ==== src/asc_ctrl.sv ====
// Purpose: Controller driving an asynchronous 64K x 8 SRAM with two selects.
// Assumes: Read data pins are sampled synchronously to clk_i.
// Notes:   Every pin comes from a flip-flop so no glitch can open a write window.
//
// Functional notes
// - Write happens only while both selects and write strobe are asserted together.
// - Hold the write window open at least the minimum write pulse.
// - Keep the chip selected long enough before the write ends.
// - Address is valid no later than the write window opens.
// - Address stays stable long enough before the write ends.
// - Honour write recovery before changing the address.
// - Drive write data long enough before the write ends.
// - Hold write data after the write ends for the hold time.
// - Space successive reads and writes by the minimum cycle times.
`timescale 1ns/1ps
module asc_ctrl
#(
  parameter int ADDR_W = asc_pkg::ADDR_W,
  parameter int DATA_W = asc_pkg::DATA_W
)
(
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              req_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  output logic                   ready_o,
  output logic                   rvalid_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic [ADDR_W-1:0]      address_lines_o,
  input  wire logic [DATA_W-1:0] data_lines_i,
  output logic [DATA_W-1:0]      data_lines_o,
  output logic                   data_lines_oe_o,
  output logic                   select_low_active_n_o,
  output logic                   select_high_active_o,
  output logic                   write_strobe_n_o,
  output logic                   output_enable_n_o
);

  localparam int CW = asc_pkg::CNT_W;

  asc_pkg::asc_state_type state;
  asc_pkg::asc_state_type next_state;
  logic [ADDR_W-1:0]      addr;
  logic [ADDR_W-1:0]      next_addr;
  logic [DATA_W-1:0]      wdata;
  logic [DATA_W-1:0]      next_wdata;
  logic                   wdrv;
  logic                   next_wdrv;
  logic                   sel;
  logic                   next_sel;
  logic                   we;
  logic                   next_we;
  logic                   oe;
  logic                   next_oe;
  logic                   sel_n;
  logic                   next_sel_n;
  logic                   we_n;
  logic                   next_we_n;
  logic                   oe_n;
  logic                   next_oe_n;
  logic                   rdy;
  logic                   next_rdy;
  logic                   rv;
  logic                   next_rv;
  logic [DATA_W-1:0]      rdata;
  logic [DATA_W-1:0]      next_rdata;
  logic                   t_load;
  logic [CW-1:0]          t_value;
  logic                   t_done;
  logic                   c_load;
  logic [CW-1:0]          c_value;
  logic                   c_done;

  // Phase timer paces each step inside an access.
  asc_timer #(.CNT_W(CW)) u_phase
  (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .load_i  (t_load),
    .value_i (t_value),
    .done_o  (t_done)
  );

  // Cycle timer enforces the least spacing between access starts.
  asc_timer #(.CNT_W(CW)) u_cycle
  (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .load_i  (c_load),
    .value_i (c_value),
    .done_o  (c_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer next-state logic.
  always_comb
  begin
    next_state = state;
    next_addr  = addr;
    next_wdata = wdata;
    next_wdrv  = wdrv;
    next_sel   = sel;
    next_we    = we;
    next_oe    = oe;
    next_rdy   = rdy;
    next_rv    = 1'b0;
    next_rdata = rdata;
    t_load     = 1'b0;
    t_value    = '0;
    c_load     = 1'b0;
    c_value    = '0;
    case (state)
      asc_pkg::ASC_IDLE:
      begin
        if (req_i && rdy)
        begin
          next_rdy  = 1'b0;
          next_addr = req_addr_i;
          next_sel  = 1'b1;
          c_load    = 1'b1;
          t_load    = 1'b1;
          if (req_write_i)
          begin
            next_wdata = req_wdata_i;
            next_wdrv  = 1'b1;
            c_value    = CW'(asc_pkg::WRITE_CYCLE_CYC);
            t_value    = CW'(asc_pkg::ADDR_SETUP_CYC);
            next_state = asc_pkg::ASC_WSET;
          end
          else
          begin
            next_oe    = 1'b1;
            c_value    = CW'(asc_pkg::READ_CYCLE_CYC);
            t_value    = CW'(asc_pkg::READ_CYCLE_CYC);
            next_state = asc_pkg::ASC_RACC;
          end
        end
        else
        begin
          next_rdy = c_done;
        end
      end
      asc_pkg::ASC_WSET:
      begin
        // Strobe falls last, so the window opens on it with address and data settled.
        if (t_done)
        begin
          next_we    = 1'b1;
          t_load     = 1'b1;
          t_value    = CW'(asc_pkg::SEL_WEND_CYC);
          next_state = asc_pkg::ASC_WPUL;
        end
      end
      asc_pkg::ASC_WPUL:
      begin
        // The select-to-write-end figure alone sets the window; pulse, address and data fit inside it.
        if (t_done)
        begin
          next_we    = 1'b0;
          t_load     = 1'b1;
          t_value    = CW'(asc_pkg::DATA_HOLD_CYC);
          next_state = asc_pkg::ASC_WREC;
        end
      end
      asc_pkg::ASC_WREC:
      begin
        // Selects and data driver drop only after the strobe, so the strobe ends the write.
        if (t_done)
        begin
          next_sel   = 1'b0;
          next_wdrv  = 1'b0;
          next_state = asc_pkg::ASC_IDLE;
        end
      end
      asc_pkg::ASC_RACC:
      begin
        if (t_done)
        begin
          next_rdata = data_lines_i;
          next_rv    = 1'b1;
          next_oe    = 1'b0;
          next_sel   = 1'b0;
          t_load     = 1'b1;
          t_value    = CW'(asc_pkg::FLOAT_CYC);
          next_state = asc_pkg::ASC_RFLT;
        end
      end
      asc_pkg::ASC_RFLT:
      begin
        // Waiting out the float time keeps a following write off a driven bus.
        if (t_done)
        begin
          next_state = asc_pkg::ASC_IDLE;
        end
      end
      default:
      begin
        next_state = asc_pkg::ASC_IDLE;
        next_sel   = 1'b0;
        next_we    = 1'b0;
        next_oe    = 1'b0;
        next_wdrv  = 1'b0;
      end
    endcase
    // Active-low pins get flops of their own, so no inverter sits between flop and pin.
    next_sel_n = ~next_sel;
    next_we_n  = ~next_we;
    next_oe_n  = ~next_oe;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer registers.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state <= asc_pkg::ASC_IDLE;
      addr  <= '0;
      wdata <= '0;
      wdrv  <= 1'b0;
      sel   <= 1'b0;
      we    <= 1'b0;
      oe    <= 1'b0;
      rdy   <= 1'b0;
      rv    <= 1'b0;
      rdata <= '0;
      sel_n <= 1'b1;
      we_n  <= 1'b1;
      oe_n  <= 1'b1;
    end
    else
    begin
      state <= next_state;
      addr  <= next_addr;
      wdata <= next_wdata;
      wdrv  <= next_wdrv;
      sel   <= next_sel;
      we    <= next_we;
      oe    <= next_oe;
      rdy   <= next_rdy;
      rv    <= next_rv;
      rdata <= next_rdata;
      sel_n <= next_sel_n;
      we_n  <= next_we_n;
      oe_n  <= next_oe_n;
    end
  end

  // Pin and user outputs, each a direct flip-flop output.
  assign address_lines_o       = addr;
  assign data_lines_o          = wdata;
  assign data_lines_oe_o       = wdrv;
  assign select_low_active_n_o = sel_n;
  assign select_high_active_o  = sel;
  assign write_strobe_n_o      = we_n;
  assign output_enable_n_o     = oe_n;
  assign ready_o               = rdy;
  assign rvalid_o              = rv;
  assign rdata_o               = rdata;

endmodule

// ==== src/asc_timer.sv ====
// Purpose: Down counter that marks when a loaded number of cycles has passed.
// Assumes: Load and count values fit CNT_W bits.
// Notes:   Done is high while the count is zero.
`timescale 1ns/1ps
module asc_timer
#(
  parameter int CNT_W = 8
)
(
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] value_i,
  output logic                  done_o
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  // Load wins over counting so a new phase always starts from its full length.
  always_comb
  begin
    next_count = count;
    if (load_i)
    begin
      next_count = value_i;
    end
    else if (count != '0)
    begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      count <= '0;
    end
    else
    begin
      count <= next_count;
    end
  end

  assign done_o = (count == '0);

endmodule

// ==== test/asc_ctrl_tb_top.sv ====
// Purpose: Self-checking bench for the SRAM controller.
// Assumes: Requests are driven on falling edges.
// Notes:   Every path ends in print_verdict.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module asc_ctrl_tb_top;
  logic                       clk_i, rstn_i, req_i, req_write_i, ready_o, rvalid_o;
  logic [asc_pkg::ADDR_W-1:0] req_addr_i, address_lines_o;
  logic [asc_pkg::DATA_W-1:0] req_wdata_i, rdata_o, data_lines_o, dq_dev, dq_bus;
  logic                       data_lines_oe_o, sel_n, sel, we_n, oe_n;
  int                         miscompares, checks;
  // Free-running 100 MHz clock.
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // The controller wins the shared bus whenever it drives.
  assign dq_bus = data_lines_oe_o ? data_lines_o : dq_dev;
  asc_ctrl uut (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .ready_o(ready_o),
    .rvalid_o(rvalid_o), .rdata_o(rdata_o), .address_lines_o(address_lines_o),
    .data_lines_i(dq_bus), .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o),
    .select_low_active_n_o(sel_n), .select_high_active_o(sel), .write_strobe_n_o(we_n),
    .output_enable_n_o(oe_n));
  asc_sram_model #(.DLY_NS(60)) u_ram (.addr_i(address_lines_o), .dq_i(dq_bus),
    .dq_o(dq_dev), .sel_n_i(sel_n), .sel_i(sel), .we_n_i(we_n), .oe_n_i(oe_n));
  //////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait for ready or read valid; a hang counts as a mismatch.
  task automatic wait_for(input bit pick, output int n);
    n = 0;
    while ((pick ? rvalid_o : ready_o) !== 1'b1 && n < 50)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n == 50)
    begin
      miscompares++;
      print_verdict();
    end
  endtask
  task automatic issue(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n;
    wait_for(1'b0, n);
    req_i = 1'b1;
    req_write_i = w;
    req_addr_i = a;
    req_wdata_i = d;
    @(negedge clk_i);
    req_i = 1'b0;
  endtask
  task automatic read_chk(input logic [15:0] a, input logic [7:0] e);
    int n;
    issue(1'b0, a, 8'h00);
    wait_for(1'b1, n);
    `CHK(n, 8)
    `CHK(rdata_o, e)
    @(negedge clk_i);
    `CHK(rvalid_o, 1'b0)
  endtask
  task automatic t_idle();
    `CHK({sel_n, sel, we_n, oe_n, data_lines_oe_o}, 5'b10110)
    $display("test idle done");
  endtask
  task automatic t_rw();
    logic [15:0] a [4] = '{16'h0000, 16'hffff, 16'h1234, 16'h8001};
    logic [7:0]  d [4] = '{8'ha5, 8'h5a, 8'h00, 8'hff};
    for (int i = 0; i < 4; i++)
      issue(1'b1, a[i], d[i]);
    for (int i = 0; i < 4; i++)
      read_chk(a[i], d[i]);
    $display("test edges done");
  endtask
  // A request while busy must be dropped without trace.
  task automatic t_refused();
    int n;
    issue(1'b1, 16'h4000, 8'h11);
    @(negedge clk_i);
    req_i = 1'b1;
    req_wdata_i = 8'hee;
    @(negedge clk_i);
    req_i = 1'b0;
    wait_for(1'b0, n);
    `CHK(n >= 5, 1'b1)
    read_chk(16'h4000, 8'h11);
    $display("test refused done");
  endtask
  task automatic t_overwrite();
    issue(1'b1, 16'h00ff, 8'h81);
    issue(1'b1, 16'h0100, 8'hc3);
    issue(1'b1, 16'h00ff, 8'h7e);
    read_chk(16'h00ff, 8'h7e);
    read_chk(16'h0100, 8'hc3);
    $display("test overwrite done");
  endtask
  // Main sequence.
  initial
  begin
    rstn_i = 1'b0;
    req_i = 1'b0;
    req_write_i = 1'b0;
    req_addr_i = 16'h0000;
    req_wdata_i = 8'h00;
    repeat (8) @(negedge clk_i);
    t_idle();
    rstn_i = 1'b1;
    t_rw();
    t_refused();
    t_overwrite();
    print_verdict();
  end
  // Run limit.
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    print_verdict();
  end
endmodule

// ==== test/asc_monitor.sv ====
// Purpose: Port checker for the SRAM controller.
// Assumes: Write and read walks of the controller at 10 ns a cycle.
// Notes:   Bound to asc_ctrl at the foot of this file.
`timescale 1ns/1ps
module asc_monitor
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
)
(
  input wire logic              clk_i,
  input wire logic              rstn_i,
  input wire logic              req_i,
  input wire logic              req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic              ready_o,
  input wire logic              rvalid_o,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic [ADDR_W-1:0] address_lines_o,
  input wire logic [DATA_W-1:0] data_lines_i,
  input wire logic [DATA_W-1:0] data_lines_o,
  input wire logic              data_lines_oe_o,
  input wire logic              select_low_active_n_o,
  input wire logic              select_high_active_o,
  input wire logic              write_strobe_n_o,
  input wire logic              output_enable_n_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  // The chip counts as selected only with both selects asserted.
  logic sel_on;
  assign sel_on = !select_low_active_n_o && select_high_active_o;
  //////////////////////////////////////////////////////////////
  // Write window, access spacing and read cycle: seven strobe cycles cover pulse, select and address figures.
  a_strobe_in_sel:
    assert property (!write_strobe_n_o |-> sel_on) else $error("strobe outside select");
  a_write_pulse_len:
    assert property ($fell(write_strobe_n_o) |-> (!write_strobe_n_o)[*7] ##1 write_strobe_n_o)
    else $error("write pulse length wrong");
  a_sel_before_end:
    assert property ($rose(write_strobe_n_o) |-> sel_on && $past(sel_on, 7))
    else $error("select too short before write end");
  a_addr_setup:
    assert property ($fell(write_strobe_n_o) |-> $stable(address_lines_o) && $past(sel_on))
    else $error("address not ready at write start");
  a_addr_held:
    assert property (!write_strobe_n_o |-> $stable(address_lines_o)) else $error("address moved");
  a_data_overlap:
    assert property (!write_strobe_n_o |-> data_lines_oe_o && $stable(data_lines_o))
    else $error("write data not held");
  a_write_recovery:
    assert property ($rose(write_strobe_n_o) |-> data_lines_oe_o && $stable(data_lines_o)
      ##1 $stable(address_lines_o)) else $error("no hold after write end");
  a_start_spacing:
    assert property (req_i && ready_o |=> (!ready_o)[*6]) else $error("accesses too close");
  a_read_cycle:
    assert property (req_i && ready_o && !req_write_i |=> (!output_enable_n_o && sel_on)[*8]
      ##1 rvalid_o) else $error("read cycle wrong");
  // Main scenarios reached.
  c_write: cover property ($fell(write_strobe_n_o));
  c_read: cover property (rvalid_o);
  c_busy_req: cover property (req_i && !ready_o);
endmodule
bind asc_ctrl asc_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mon (
  .clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .req_write_i(req_write_i),
  .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .ready_o(ready_o), .rvalid_o(rvalid_o),
  .rdata_o(rdata_o), .address_lines_o(address_lines_o), .data_lines_i(data_lines_i),
  .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o),
  .select_low_active_n_o(select_low_active_n_o), .select_high_active_o(select_high_active_o),
  .write_strobe_n_o(write_strobe_n_o), .output_enable_n_o(output_enable_n_o));

// ==== test/asc_sram_model.sv ====
// Purpose: Behavioural 64K x 8 static RAM with two selects.
// Assumes: Pins change only from the controller's flip-flops.
// Notes:   Read data appears DLY_NS after its cause.
`timescale 1ns/1ps
module asc_sram_model
#(
  parameter int DLY_NS = 35
)
(
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  dq_i,
  output logic [7:0]       dq_o,
  input  wire logic        sel_n_i,
  input  wire logic        sel_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i
);
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  logic       chosen;
  logic       rd;
  // Either select alone powers the part down.
  assign chosen = !sel_n_i && sel_i;
  assign rd = chosen && we_n_i && !oe_n_i;
  // Store at the close of the overlap, whichever pin closes it first.
  always @(negedge (chosen && !we_n_i))
    mem[addr_i] = dq_i;
  // Floating pins show the inverse of the last value so a late sample never passes by luck.
  always_latch if (rd) last = mem[addr_i];
  assign #(DLY_NS) dq_o = rd ? last : ~last;
endmodule
